// ===== rtl/tpo_map.svh
`ifndef TPO_MAP_SVH
`define TPO_MAP_SVH
`define TPO_ADDR_W 8
`define TPO_CTRL_OFS 8'h00
`define TPO_STAT_OFS 8'h04
`define TPO_EMU_OFS 8'h08
`define TPO_CTRL_ROUTE 0
`define TPO_CTRL_SWIRQ 1
`define TPO_CTRL_RST 2'h1
`define TPO_SYNC_W 7
`define TPO_IR_W 4
`define TPO_IR_BYPASS 4'hF
`define TPO_IR_EMU 4'h2
`define TPO_IR_CAPTURE 4'h1
`define TPO_PIN0_VAL 0
`define TPO_PIN0_DRV 1
`define TPO_EMU1_VAL 2
`define TPO_EMU1_DRV 3
`endif

// ===== rtl/tpo_pkg.sv
package tpo_pkg;
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR, TAP_EX2_DR,
    TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
  } tpo_tap_t;
  typedef logic [31:0] tpo_word_t;
endpackage : tpo_pkg

// ===== rtl/tpo_sync.sv
`timescale 1ns/1ps
module tpo_sync #(
  parameter int W = 1
) (
  // Clock
  input wire logic clk,
  // Asynchronous levels in, synchronised out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        meta_r[i] <= d[i];
        q[i] <= meta_r[i];
      end
    end
  endgenerate
endmodule : tpo_sync

// ===== rtl/tpo_top.sv
`timescale 1ns/1ps
`include "tpo_map.svh"
module tpo_top (
  // Clock and device reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TPO_ADDR_W-1:0] paddr,
  input wire tpo_pkg::tpo_word_t pwdata,
  output tpo_pkg::tpo_word_t prdata,
  output logic pready,
  output logic pslverr,
  // Core side
  input wire logic host_irq_req,
  input wire logic host_port_rdy_core,
  input wire logic timer1_out,
  output logic host_port_enable,
  output logic scan_mode,
  output logic output_off,
  // Straps and test pins
  input wire logic host_port_enable_strap,
  input wire logic test_rst,
  input wire logic test_clk,
  input wire logic test_mode_sel,
  input wire logic test_din,
  output logic test_dout,
  output logic test_dout_oe_n,
  // Emulator pins
  input wire logic emulator_pin0_in,
  output logic emulator_pin0_out,
  output logic emulator_pin0_oe_n,
  input wire logic emulator_pin1_output_off_in,
  output logic emulator_pin1_output_off_out,
  output logic emulator_pin1_output_off_oe_n,
  // Host port pins
  output logic host_irq_out,
  output logic host_irq_out_oe_n,
  output logic host_port_ready,
  output logic host_port_ready_oe_n
);
  import tpo_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [`TPO_SYNC_W-1:0] pins_s;
  logic strap_s, trst_s, tck_s, tms_s, tdi_s, pin0_s, emu1_s;

  tpo_sync #(.W(`TPO_SYNC_W)) u_sync (
    .clk(sys_clk),
    .d({host_port_enable_strap, test_rst, test_clk, test_mode_sel, test_din,
        emulator_pin0_in, emulator_pin1_output_off_in}),
    .q(pins_s)
  );
  assign {strap_s, trst_s, tck_s, tms_s, tdi_s, pin0_s, emu1_s} = pins_s;

  ////////////////////////////////////////////////////////////////////////////
  // Strap latch and mode
  logic en_r, en_nxt, rst_seen_r, rst_seen_nxt;
  logic scan_r, scan_nxt, off_r, off_nxt;

  always_comb begin
    en_nxt = en_r;
    rst_seen_nxt = 1'b0;
    scan_nxt = trst_s;
    off_nxt = ~trst_s & ~emu1_s;
    if (!reset_n) begin
      en_nxt = 1'b0;
      rst_seen_nxt = 1'b1;
    end else if (rst_seen_r) begin
      // Strap is caught only at the first edge after release
      en_nxt = strap_s;
    end
  end

  always_ff @(posedge sys_clk) begin
    en_r <= en_nxt;
    rst_seen_r <= rst_seen_nxt;
    scan_r <= scan_nxt;
    off_r <= off_nxt;
  end

  assign host_port_enable = en_r;
  assign scan_mode = scan_r;
  assign output_off = off_r;

  ////////////////////////////////////////////////////////////////////////////
  // Test access port, clocked by sampled test clock edges
  logic tck_d_r, tck_rise, tck_fall;
  tpo_tap_t tap_r, tap_nxt;
  logic [`TPO_IR_W-1:0] ir_r, ir_nxt, irsh_r, irsh_nxt;
  logic [3:0] emush_r, emush_nxt, emu_dr_r, emu_dr_nxt;
  logic byp_r, byp_nxt, tdo_r, tdo_nxt, tdo_en_r, tdo_en_nxt;
  logic emu_sel;

  function automatic tpo_tap_t tap_step(input tpo_tap_t s, input logic m);
    unique case (s)
      TAP_RESET: tap_step = m ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_step = m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_step = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: tap_step = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_step = m ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: tap_step = m ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: tap_step = m ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_step = m ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: tap_step = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: tap_step = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_step = m ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: tap_step = m ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: tap_step = m ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
    endcase
  endfunction : tap_step

  assign tck_rise = tck_s & ~tck_d_r;
  assign tck_fall = ~tck_s & tck_d_r;
  assign emu_sel = (ir_r == `TPO_IR_EMU);

  always_comb begin
    tap_nxt = tap_r;
    ir_nxt = ir_r;
    irsh_nxt = irsh_r;
    emush_nxt = emush_r;
    emu_dr_nxt = emu_dr_r;
    byp_nxt = byp_r;
    tdo_nxt = tdo_r;
    tdo_en_nxt = tdo_en_r;
    if (!reset_n || !trst_s) begin
      // Functional mode holds the port in reset
      tap_nxt = TAP_RESET;
      ir_nxt = `TPO_IR_BYPASS;
      emu_dr_nxt = 4'h0;
      tdo_en_nxt = 1'b0;
      // Known shift contents, so the first fall never puts an unknown on the pin
      byp_nxt = 1'b0;
      emush_nxt = 4'h0;
      tdo_nxt = 1'b0;
    end else if (tck_rise) begin
      tap_nxt = tap_step(tap_r, tms_s);
      unique case (tap_r)
        TAP_RESET: begin
          ir_nxt = `TPO_IR_BYPASS;
          emu_dr_nxt = 4'h0;
        end
        TAP_CAP_IR: irsh_nxt = `TPO_IR_CAPTURE;
        TAP_SH_IR: irsh_nxt = {tdi_s, irsh_r[`TPO_IR_W-1:1]};
        TAP_UPD_IR: ir_nxt = irsh_r;
        TAP_CAP_DR: begin
          byp_nxt = 1'b0;
          emush_nxt = emu_dr_r;
        end
        TAP_SH_DR: begin
          byp_nxt = tdi_s;
          if (emu_sel) begin
            emush_nxt = {tdi_s, emush_r[3:1]};
          end
        end
        TAP_UPD_DR: begin
          if (emu_sel) begin
            emu_dr_nxt = emush_r;
          end
        end
        default: ;
      endcase
    end else if (tck_fall) begin
      // Output moves on falls so the tester samples on rises
      tdo_en_nxt = (tap_r == TAP_SH_DR) || (tap_r == TAP_SH_IR);
      if (tap_r == TAP_SH_IR) begin
        tdo_nxt = irsh_r[0];
      end else begin
        tdo_nxt = emu_sel ? emush_r[0] : byp_r;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    tck_d_r <= tck_s;
    tap_r <= tap_nxt;
    ir_r <= ir_nxt;
    irsh_r <= irsh_nxt;
    emush_r <= emush_nxt;
    emu_dr_r <= emu_dr_nxt;
    byp_r <= byp_nxt;
    tdo_r <= tdo_nxt;
    tdo_en_r <= tdo_en_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers
  logic [1:0] ctrl_r, ctrl_nxt;
  logic irq_nxt, irq_oe_n_nxt, rdy_nxt, rdy_oe_n_nxt, tdo_oe_n_nxt;
  logic e0_nxt, e0_oe_n_nxt, e1_nxt, e1_oe_n_nxt, irq_src;

  always_comb begin
    irq_src = 1'b1;
    if (en_r) begin
      irq_src = ~(host_irq_req | ctrl_r[`TPO_CTRL_SWIRQ]);
    end else if (ctrl_r[`TPO_CTRL_ROUTE]) begin
      irq_src = timer1_out;
    end
    irq_nxt = reset_n ? irq_src : 1'b1;
    irq_oe_n_nxt = off_nxt;
    rdy_nxt = host_port_rdy_core;
    rdy_oe_n_nxt = off_nxt;
    tdo_oe_n_nxt = off_nxt | ~tdo_en_r;
    e0_nxt = emu_dr_r[`TPO_PIN0_VAL];
    e1_nxt = emu_dr_r[`TPO_EMU1_VAL];
    // Direction comes from the scan chain only in scan mode
    e0_oe_n_nxt = off_nxt | ~trst_s | ~emu_dr_r[`TPO_PIN0_DRV];
    e1_oe_n_nxt = off_nxt | ~trst_s | ~emu_dr_r[`TPO_EMU1_DRV];
  end

  always_ff @(posedge sys_clk) begin
    host_irq_out <= irq_nxt;
    host_irq_out_oe_n <= irq_oe_n_nxt;
    host_port_ready <= rdy_nxt;
    host_port_ready_oe_n <= rdy_oe_n_nxt;
    test_dout <= tdo_r;
    test_dout_oe_n <= tdo_oe_n_nxt;
    emulator_pin0_out <= e0_nxt;
    emulator_pin0_oe_n <= e0_oe_n_nxt;
    emulator_pin1_output_off_out <= e1_nxt;
    emulator_pin1_output_off_oe_n <= e1_oe_n_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB registers, zero wait states
  tpo_word_t rd_nxt, prdata_r;
  logic err_nxt, err_r;

  function automatic logic reg_hit(input logic [`TPO_ADDR_W-1:0] a);
    reg_hit = (a == `TPO_CTRL_OFS) || (a == `TPO_STAT_OFS) || (a == `TPO_EMU_OFS);
  endfunction : reg_hit

  always_comb begin
    ctrl_nxt = ctrl_r;
    rd_nxt = prdata_r;
    err_nxt = err_r;
    if (!reset_n) begin
      ctrl_nxt = `TPO_CTRL_RST;
      rd_nxt = 32'h0000_0000;
      err_nxt = 1'b0;
    end else if (psel && !penable) begin
      // Data and error are fixed in setup so the access phase sees flops
      err_nxt = ~reg_hit(paddr);
      unique case (paddr)
        `TPO_CTRL_OFS: rd_nxt = {30'h0000_0000, ctrl_r};
        `TPO_STAT_OFS: rd_nxt = {23'h00_0000, tap_r, emu1_s, pin0_s, off_r, scan_r, en_r};
        `TPO_EMU_OFS: rd_nxt = {28'h000_0000, emu_dr_r};
        default: rd_nxt = 32'h0000_0000;
      endcase
    end else if (psel && penable && pwrite && paddr == `TPO_CTRL_OFS) begin
      ctrl_nxt = pwdata[1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    ctrl_r <= ctrl_nxt;
    prdata_r <= rd_nxt;
    err_r <= err_nxt;
  end

  assign prdata = prdata_r;
  assign pslverr = err_r & psel & penable;
  assign pready = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence rst_release_s;
    $rose(reset_n);
  endsequence
  sequence off_req_s;
    !trst_s && !emu1_s;
  endsequence

  irq_reset_high_a: assert property (@(posedge sys_clk) !reset_n |=> host_irq_out)
    else $error("host interrupt not high in reset");
  irq_off_float_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    off_req_s |=> host_irq_out_oe_n)
    else $error("host interrupt driven during output off");
  strap_sample_a: assert property (@(posedge sys_clk)
    rst_release_s |=> host_port_enable == $past(strap_s))
    else $error("strap not latched at reset release");
  strap_low_off_a: assert property (@(posedge sys_clk)
    rst_release_s and !strap_s |=> !host_port_enable)
    else $error("port enabled with strap low");
  strap_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !$rose(reset_n) |=> $stable(host_port_enable))
    else $error("port enable changed between resets");
  timer_route_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !en_r && ctrl_r[`TPO_CTRL_ROUTE] |=> host_irq_out == $past(timer1_out))
    else $error("timer 1 not on interrupt pin");
  bypass_capture_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tck_rise && trst_s && tap_r == TAP_SH_DR |=> byp_r == $past(tdi_s))
    else $error("bypass missed test data");
  tdo_fall_only_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !tck_fall && trst_s |=> $stable(tdo_r))
    else $error("test data out moved off a fall");
  tdo_float_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tck_fall && tap_r != TAP_SH_DR && tap_r != TAP_SH_IR |=> ##1 test_dout_oe_n)
    else $error("test data out driven outside shift");
  tdo_off_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    off_req_s |=> test_dout_oe_n)
    else $error("test data out driven during output off");
  func_tap_reset_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !trst_s |=> tap_r == TAP_RESET && !tdo_en_r)
    else $error("scan port active in functional mode");
  emu_scan_drive_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    trst_s && emu_dr_r[`TPO_PIN0_DRV] |=> !emulator_pin0_oe_n && scan_mode)
    else $error("emulator pin 0 not driven in scan mode");
  emu_func_in_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !trst_s |=> emulator_pin1_output_off_oe_n && emulator_pin0_oe_n)
    else $error("emulator pin driven in functional mode");
  ready_off_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    off_req_s |=> host_port_ready_oe_n)
    else $error("host ready driven during output off");
endmodule : tpo_top

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import tpo_pkg::*;
  logic sys_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  tpo_word_t pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, err;
  logic host_irq_req = 1'b0, host_port_rdy_core = 1'b1, timer1_out = 1'b0;
  // Held high through reset to enable the port
  logic host_port_enable_strap = 1'b1;
  logic host_port_enable, scan_mode, output_off, test_dout_oe_n, host_irq_out, host_irq_out_oe_n;
  logic host_port_ready_oe_n, test_rst, test_clk, test_mode_sel, test_din, pin0_lvl, emu1_lvl;
  logic host_port_ready, test_dout;
  logic emulator_pin0_in, emulator_pin0_out, emulator_pin0_oe_n;
  logic emulator_pin1_output_off_in, emulator_pin1_output_off_out, emulator_pin1_output_off_oe_n;
  int fail_count = 0, check_count = 0, cyc = 0;
  always #12.5 sys_clk = ~sys_clk;
  // Emulator releases a pin while the device drives it
  assign emulator_pin0_in = emulator_pin0_oe_n ? pin0_lvl : emulator_pin0_out;
  assign emulator_pin1_output_off_in = emulator_pin1_output_off_oe_n ? emu1_lvl : emulator_pin1_output_off_out;
  tpo_far far (.sys_clk, .test_rst, .test_clk, .test_mode_sel, .test_din, .pin0_lvl, .emu1_lvl);
  tpo_top dut (.sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .host_irq_req, .host_port_rdy_core, .timer1_out, .host_port_enable, .scan_mode, .output_off,
    .host_port_enable_strap, .test_rst, .test_clk, .test_mode_sel, .test_din, .test_dout,
    .test_dout_oe_n, .emulator_pin0_in, .emulator_pin0_out, .emulator_pin0_oe_n,
    .emulator_pin1_output_off_in, .emulator_pin1_output_off_out, .emulator_pin1_output_off_oe_n,
    .host_irq_out, .host_irq_out_oe_n, .host_port_ready, .host_port_ready_oe_n);
  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input tpo_word_t got, input tpo_word_t exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // One transfer plus an idle cycle, so the next setup never collides
  task automatic apb(input logic wr, input logic [7:0] a, input tpo_word_t d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task automatic walk(input logic [15:0] tms, input logic [15:0] tdi, input int n);
    for (int i = 0; i < n; i++) begin
      far.step(tms[i], tdi[i]);
    end
  endtask : walk
  task automatic reset_cycle;
    reset_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk("irq pin in reset", host_irq_out, 1);
    chk("enable in reset", host_port_enable, 0);
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
  endtask : reset_cycle
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    reset_cycle();
    chk("enable latched", host_port_enable, 1);
    host_port_enable_strap <= 1'b0;
    host_irq_req <= 1'b1;
    host_port_rdy_core <= 1'b0;
    repeat (8) @(posedge sys_clk);
    chk("enable held", host_port_enable, 1);
    chk("irq pin asserted", host_irq_out, 0);
    chk("ready follows core", host_port_ready, 0);
    host_irq_req <= 1'b0;
    apb(1'b0, 8'h00, 0);
    chk("ctrl reset", rd, 32'h0000_0001);
    apb(1'b1, 8'h00, 32'h0000_0002);
    apb(1'b0, 8'h00, 0);
    chk("ctrl readback", rd, 32'h0000_0002);
    chk("software irq", host_irq_out, 0);
    apb(1'b0, 8'h0C, 0);
    chk("unmapped error", err, 1);
    chk("unmapped data", rd, 0);
    apb(1'b0, 8'h04, 0);
    chk("status enable", rd[2:0], 3'h1);
    $display("test enabled port done");
    reset_cycle();
    chk("enable off", host_port_enable, 0);
    host_port_enable_strap <= 1'b1;
    timer1_out <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk("strap ignored", host_port_enable, 0);
    chk("timer high", host_irq_out, 1);
    timer1_out <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("timer low", host_irq_out, 0);
    $display("test disabled port done");
    far.set_mode(1'b0, 1'b1);
    repeat (6) @(posedge sys_clk);
    chk("off state", output_off, 1);
    chk("irq pin float", host_irq_out_oe_n, 1);
    chk("ready float", host_port_ready_oe_n, 1);
    chk("tdo float off", test_dout_oe_n, 1);
    far.set_mode(1'b0, 1'b0);
    repeat (6) @(posedge sys_clk);
    chk("irq pin driven", host_irq_out_oe_n, 0);
    chk("ready driven", host_port_ready_oe_n, 0);
    walk(16'h00DF, 16'h0000, 10);
    apb(1'b0, 8'h04, 0);
    chk("tap held", rd[8:5], TAP_RESET);
    chk("pin0 idle", emulator_pin0_oe_n, 1);
    $display("test functional mode done");
    far.set_mode(1'b1, 1'b0);
    repeat (6) @(posedge sys_clk);
    chk("scan mode", scan_mode, 1);
    chk("tdo float idle", test_dout_oe_n, 1);
    walk(16'h00DF, 16'h0000, 10);
    walk(16'h0000, 16'h0002, 3);
    chk("tdo shifting", test_dout_oe_n, 0);
    chk("tdo data", test_dout, 0);
    walk(16'h0003, 16'h0000, 3);
    repeat (6) @(posedge sys_clk);
    apb(1'b0, 8'h04, 0);
    chk("tap idle", rd[8:5], TAP_IDLE);
    chk("status pins", rd[4:0], 5'h1A);
    walk(16'h00C1, 16'h0078, 9);
    repeat (12) @(posedge sys_clk);
    chk("tdo float after", test_dout_oe_n, 1);
    chk("pin0 driven", emulator_pin0_oe_n, 0);
    chk("pin0 value", emulator_pin0_out, 1);
    chk("emu1 driven", emulator_pin1_output_off_oe_n, 0);
    chk("emu1 value", emulator_pin1_output_off_out, 1);
    apb(1'b0, 8'h08, 0);
    chk("emu register", rd, 32'h0000_000F);
    $display("test scan mode done");
    results();
  end
endmodule : tb_top

// ===== test/tpo_far.sv
`timescale 1ns/1ps
module tpo_far (
  // System clock
  input wire logic sys_clk,
  // Scan link and emulator pin levels
  output logic test_rst,
  output logic test_clk,
  output logic test_mode_sel,
  output logic test_din,
  output logic pin0_lvl,
  output logic emu1_lvl
);
  initial begin
    test_rst = 1'b0;
    test_clk = 1'b0;
    test_mode_sel = 1'b1;
    test_din = 1'b1;
    pin0_lvl = 1'b1;
    emu1_lvl = 1'b1;
  end
  // Free running, as a tester's scan clock normally is
  always #100 test_clk = ~test_clk;
  ////////////////////////////////////////////////////////////
  // Off pattern is only ever applied for test, never for bus sharing
  task automatic set_mode(input logic scan, input logic off);
    @(posedge sys_clk);
    test_rst <= scan;
    pin0_lvl <= 1'b1;
    emu1_lvl <= ~off;
  endtask : set_mode
  // New levels after a fall, so they are steady at the rise
  task automatic step(input logic tms, input logic tdi);
    @(negedge test_clk);
    test_mode_sel <= tms;
    test_din <= tdi;
    @(posedge test_clk);
  endtask : step
endmodule : tpo_far
